// [core/pcr_plugon_regs.sv]
// How it works
// - Open detect is one enable shared by all eight channels of the plug-on.
// - Open detect is only on or off and comes up off.
// - Identity read at plug-on times 40 hex answers the identity value.
// - Sample-and-hold channel register one holds gain code FFFF, FFF1, FFF2 or FFF3.
// - Direct-input channel gain takes only 0000, unity.
// - Channel register two uses only its low hex digit, codes 0 to 4, on sample-and-hold channels; direct-input channels keep 0.
// - Traffic arrives as register writes with address and value, reads with address.
// - Reset or reset command sets sample-and-hold gain to 0.5.
// - Reset or reset command sets sample-and-hold cutoff to 15 Hz.
`timescale 1ns/1ps
`default_nettype none

module pcr_plugon_regs
  import pcr_pkg::*;
#(
  // Arbitrary identity value; no meaning beyond this design.
  parameter logic [15:0] ID_VALUE = 16'h5A3C
)
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  // Slot strap and reset command
  input  wire logic [2:0]                  slot_strap,
  input  wire logic                        soft_reset,
  // Detect enable from the host card control bit
  input  wire logic                        detect_enable_in,
  // Conditioning bus
  input  wire pcr_req_s                    req,
  output var pcr_rsp_s                     rsp,
  // Analog controls
  output logic                             open_input_detect,
  output wire logic [NUM_CH-1:0][15:0]     gain_code_out,
  output wire logic [NUM_CH-1:0][CUT_W-1:0] cutoff_code_out
);

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_r;
  logic rst_sync_b;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Slot capture
  // The strap is caught on the first edge after release; until then the bank
  // answers nothing, which avoids decoding against a stale slot.
  logic [2:0] slot_r;
  logic       slot_ok_r;

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      slot_r    <= SLOT_RESET;
      slot_ok_r <= 1'b0;
    end
    else if (!slot_ok_r)
    begin
      slot_r    <= slot_strap;
      slot_ok_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Decode
  function automatic logic own_hit(input pcr_addr_s a, input logic [2:0] slot,
                                   input logic ok);
    own_hit = ok && (a.plugon == slot);
  endfunction

  function automatic logic is_reg(input pcr_addr_s a, input logic [1:0] region,
                                  input logic [2:0] sel);
    is_reg = (a.region == region) && (a.regsel == sel);
  endfunction

  logic hit;
  logic wr_hit;
  logic rd_hit;

  assign hit    = own_hit(req.addr, slot_r, slot_ok_r);
  assign wr_hit = hit && req.write;
  assign rd_hit = hit && req.read && !req.write;

  // ==========================================================================
  // Whole plug-on register one
  logic [15:0] second_r;

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      second_r <= SECOND_RESET;
    else if (soft_reset)
      second_r <= SECOND_RESET;
    else if (wr_hit && is_reg(req.addr, REGION_WHOLE, REG_SECOND) &&
             (req.addr.chan == 3'h0))
      second_r <= req.data;
  end

  // ==========================================================================
  // Channel registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      logic sel;
      assign sel = (req.addr.chan == 3'(gi));
      pcr_channel_reg #(
        .SAMPLE_HOLD (gi < NUM_SH)
      ) u_ch (
        .clock      (clock),
        .rst_sync_b (rst_sync_b),
        .soft_reset (soft_reset),
        .wr_gain    (wr_hit && sel && is_reg(req.addr, REGION_CHAN, REG_GAIN)),
        .wr_cutoff  (wr_hit && sel && is_reg(req.addr, REGION_CHAN, REG_CUTOFF)),
        .wdata      (req.data),
        .gain_r     (gain_code_out[gi]),
        .cutoff_r   (cutoff_code_out[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Read response
  logic [15:0] rd_data;

  always_comb
  begin
    rd_data = READ_ZERO;
    if (req.addr.region == REGION_WHOLE && req.addr.chan == 3'h0)
    begin
      if (req.addr.regsel == REG_IDENTITY)
        rd_data = ID_VALUE;
      else if (req.addr.regsel == REG_SECOND)
        rd_data = second_r;
    end
    else if (req.addr.region == REGION_CHAN)
    begin
      if (req.addr.regsel == REG_GAIN)
        rd_data = gain_code_out[req.addr.chan];
      else if (req.addr.regsel == REG_CUTOFF)
        rd_data = {CUTOFF_PAD, cutoff_code_out[req.addr.chan]};
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      rsp <= '0;
    else
    begin
      rsp.valid <= rd_hit;
      rsp.data  <= rd_hit ? rd_data : READ_ZERO;
    end
  end

  // ==========================================================================
  // Open input detect
  // one enable, default off
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      open_input_detect <= DETECT_OFF;
    else
      open_input_detect <= detect_enable_in;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  a_detect_follow: assert property (
    !$past(soft_reset) |-> open_input_detect == $past(detect_enable_in))
    else $error("open detect does not follow its enable");

  a_detect_default: assert property (
    $rose(slot_ok_r) |-> open_input_detect == DETECT_OFF || $past(detect_enable_in))
    else $error("open detect not off after reset");

  a_id_read: assert property (
    rd_hit && is_reg(req.addr, REGION_WHOLE, REG_IDENTITY) && req.addr.chan == 3'h0
    |=> rsp.valid && rsp.data == ID_VALUE)
    else $error("identity read gave wrong answer");

  a_gain_write: assert property (
    wr_hit && !soft_reset && is_reg(req.addr, REGION_CHAN, REG_GAIN) &&
    req.addr.chan == 3'h0 && (req.data == GAIN_HALF || req.data == GAIN_X8 ||
    req.data == GAIN_X64 || req.data == GAIN_X512)
    |=> gain_code_out[0] == $past(req.data))
    else $error("gain code not stored");

  a_direct_unity: assert property (
    gain_code_out[NUM_SH] == GAIN_UNITY && gain_code_out[NUM_CH-1] == GAIN_UNITY)
    else $error("direct channel gain not unity");

  a_cutoff_digit: assert property (
    wr_hit && !soft_reset && is_reg(req.addr, REGION_CHAN, REG_CUTOFF) &&
    req.addr.chan == 3'h1 && req.data[3:0] <= CUTOFF_1KHZ
    |=> cutoff_code_out[1] == $past(req.data[3:0]))
    else $error("cutoff digit not stored");

  a_soft_defaults: assert property (
    soft_reset |=> gain_code_out[0] == GAIN_HALF && gain_code_out[NUM_SH-1] == GAIN_HALF
                   && cutoff_code_out[2] == CUTOFF_15HZ)
    else $error("reset command did not restore defaults");

  a_foreign_quiet: assert property (
    req.read && req.addr.plugon != slot_r |=> !rsp.valid)
    else $error("answered an access for another plug-on");

  // direct channel gain reads back as unity
  a_direct_hold: assert property (
    rd_hit && is_reg(req.addr, REGION_CHAN, REG_GAIN) && req.addr.chan >= 3'h4
    |=> rsp.data == GAIN_UNITY)
    else $error("direct channel reported non-unity gain");

  a_read_gain: assert property (
    rd_hit && is_reg(req.addr, REGION_CHAN, REG_GAIN) && req.addr.chan == 3'h2
    |=> rsp.valid && rsp.data == $past(gain_code_out[2]))
    else $error("gain read back wrong");

  c_id_read: cover property (rd_hit && is_reg(req.addr, REGION_WHOLE, REG_IDENTITY));
  c_gain_512: cover property (gain_code_out[2] == GAIN_X512);
  c_cutoff_1k: cover property (cutoff_code_out[1] == CUTOFF_1KHZ);
  c_detect_on: cover property ($rose(open_input_detect));
  c_soft_reset: cover property (soft_reset ##1 rsp.valid);

endmodule

`default_nettype wire

// [core/pcr_pkg.sv]
`default_nettype none

package pcr_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CH = 8;
  localparam int NUM_SH = 4;
  localparam int DATA_W = 16;
  localparam int CUT_W  = 4;

  // ==========================================================================
  // Address layout and register selectors
  localparam logic [1:0] REGION_WHOLE = 2'h0;
  localparam logic [1:0] REGION_CHAN  = 2'h1;
  localparam logic [2:0] REG_IDENTITY = 3'h0;
  localparam logic [2:0] REG_SECOND   = 3'h1;
  localparam logic [2:0] REG_GAIN     = 3'h1;
  localparam logic [2:0] REG_CUTOFF   = 3'h2;

  // ==========================================================================
  // Codes and reset values
  localparam logic [15:0] GAIN_HALF     = 16'hFFFF;
  localparam logic [15:0] GAIN_X8       = 16'hFFF1;
  localparam logic [15:0] GAIN_X64      = 16'hFFF2;
  localparam logic [15:0] GAIN_X512     = 16'hFFF3;
  localparam logic [15:0] GAIN_UNITY    = 16'h0000;
  localparam logic [3:0]  CUTOFF_15HZ   = 4'h0;
  localparam logic [3:0]  CUTOFF_100HZ  = 4'h1;
  localparam logic [3:0]  CUTOFF_250HZ  = 4'h2;
  localparam logic [3:0]  CUTOFF_500HZ  = 4'h3;
  localparam logic [3:0]  CUTOFF_1KHZ   = 4'h4;
  localparam logic [15:0] SECOND_RESET  = 16'h0000;
  localparam logic [15:0] READ_ZERO     = 16'h0000;
  localparam logic [11:0] CUTOFF_PAD    = 12'h000;
  localparam logic        DETECT_OFF    = 1'b0;
  localparam logic [2:0]  SLOT_RESET    = 3'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [1:0] region;
    logic [2:0] plugon;
    logic [2:0] chan;
    logic [2:0] regsel;
  } pcr_addr_s;

  typedef struct packed {
    logic        write;
    logic        read;
    pcr_addr_s   addr;
    logic [15:0] data;
  } pcr_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } pcr_rsp_s;

endpackage

`default_nettype wire

// [core/pcr_channel_reg.sv]
`timescale 1ns/1ps
`default_nettype none

module pcr_channel_reg
  import pcr_pkg::*;
#(
  parameter int SAMPLE_HOLD = 1
)
(
  // Clock and synchronised reset
  input  wire logic        clock,
  input  wire logic        rst_sync_b,
  input  wire logic        soft_reset,
  // Write strobes from the decoder
  input  wire logic        wr_gain,
  input  wire logic        wr_cutoff,
  input  wire logic [15:0] wdata,
  // Stored settings
  output logic      [15:0] gain_r,
  output logic      [3:0]  cutoff_r
);

  localparam logic [15:0] GAIN_DEFAULT = (SAMPLE_HOLD != 0) ? GAIN_HALF : GAIN_UNITY;
  localparam logic        IS_SH        = (SAMPLE_HOLD != 0);

  function automatic logic gain_ok(input logic [15:0] code);
    if (IS_SH)
      gain_ok = (code == GAIN_HALF) || (code == GAIN_X8) ||
                (code == GAIN_X64) || (code == GAIN_X512);
    else
      gain_ok = (code == GAIN_UNITY);
  endfunction

  // ==========================================================================
  // Gain code
  // gain load and defaults
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      gain_r <= GAIN_DEFAULT;
    else if (soft_reset)
      gain_r <= GAIN_DEFAULT;
    else if (wr_gain && gain_ok(wdata))
      gain_r <= wdata;
  end

  // ==========================================================================
  // Cutoff code
  // Codes above the fastest filter are dropped so the analog side never sees
  // an unknown selection.
  // low digit only, default slowest
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      cutoff_r <= CUTOFF_15HZ;
    else if (soft_reset)
      cutoff_r <= CUTOFF_15HZ;
    else if (IS_SH && wr_cutoff && (wdata[3:0] <= CUTOFF_1KHZ))
      cutoff_r <= wdata[3:0];
  end

endmodule

`default_nettype wire

// [verif/pcr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model
  import pcr_pkg::*;
(
  // Clock
  input  wire logic     clock,
  // Conditioning bus
  output var pcr_req_s  req,
  input  wire pcr_rsp_s rsp,
  // Card control detect bit
  output var logic      detect_enable_in
);
  // ======
  // Host side
  initial
  begin
    req = '0;
    detect_enable_in = 1'b0;
  end

  task automatic xfer(input logic wr, input pcr_addr_s a, input logic [15:0] d,
                      output pcr_rsp_s got);
    @(posedge clock);
    req <= {wr, ~wr, a, d};
    @(posedge clock);
    // A released bus turns its lines round, so a stale value never passes for a held one.
    req <= {2'b00, ~a, ~d};
    #1;
    got = rsp;
  endtask

  task automatic set_detect(input logic en);
    @(posedge clock);
    detect_enable_in <= en;
    @(posedge clock);
    #1;
  endtask
endmodule

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb
  import pcr_pkg::*;
;
  localparam logic [2:0]  SLOT  = 3'h5;
  localparam logic [2:0]  OTHER = 3'h6;
  // Arbitrary identity value.
  localparam logic [15:0] ID    = 16'h3C96;

  logic                              clock = 1'b0;
  logic                              rst_b;
  logic [2:0]                        slot_strap;
  logic                              soft_reset;
  logic                              detect_enable_in;
  pcr_req_s                          req;
  pcr_rsp_s                          rsp;
  logic                              open_input_detect;
  wire logic [NUM_CH-1:0][15:0]      gain_code_out;
  wire logic [NUM_CH-1:0][CUT_W-1:0] cutoff_code_out;
  int                                errors;
  int                                checks;
  pcr_rsp_s                          r;
  logic [15:0]                       g [4] = '{GAIN_X8, GAIN_X64, GAIN_X512, GAIN_HALF};

  always #50 clock = ~clock;

  pcr_plugon_regs #(.ID_VALUE(ID)) i_pcr_plugon_regs (
    .clock(clock), .rst_b(rst_b), .slot_strap(slot_strap), .soft_reset(soft_reset),
    .detect_enable_in(detect_enable_in), .req(req), .rsp(rsp),
    .open_input_detect(open_input_detect), .gain_code_out(gain_code_out),
    .cutoff_code_out(cutoff_code_out)
  );

  pcr_host_model i_pcr_host_model (
    .clock(clock), .req(req), .rsp(rsp), .detect_enable_in(detect_enable_in)
  );

  // ======
  // Access tasks
  function automatic pcr_addr_s ca(input logic [2:0] p, input logic [2:0] c,
                                   input logic [2:0] s);
    return '{REGION_CHAN, p, c, s};
  endfunction

  function automatic pcr_addr_s wa(input logic [2:0] p, input logic [2:0] s);
    return '{REGION_WHOLE, p, 3'h0, s};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input pcr_addr_s a, input logic [15:0] d);
    i_pcr_host_model.xfer(1'b1, a, d, r);
    chk("write answer", 16'h0000, {15'h0000, r.valid});
  endtask

  task automatic rdchk(input string what, input pcr_addr_s a, input logic [15:0] exp);
    i_pcr_host_model.xfer(1'b0, a, 16'h0000, r);
    chk("read answer", 16'h0001, {15'h0000, r.valid});
    chk(what, exp, r.data);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ======
  // Tests
  initial
  begin
    rst_b = 1'b0;
    slot_strap = SLOT;
    soft_reset = 1'b0;
    errors = 0;
    checks = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    for (int c = 0; c < NUM_CH; c++)
    begin
      chk("gain reset", (c < NUM_SH) ? GAIN_HALF : GAIN_UNITY, gain_code_out[c]);
      chk("cutoff reset", 16'(CUTOFF_15HZ), 16'(cutoff_code_out[c]));
    end
    chk("detect reset", 16'(DETECT_OFF), 16'(open_input_detect));
    rdchk("second reset", wa(SLOT, REG_SECOND), SECOND_RESET);
    $display("test reset done");
    rdchk("identity", wa(SLOT, REG_IDENTITY), ID);
    wr(wa(SLOT, REG_IDENTITY), 16'hFFFF);
    rdchk("identity kept", wa(SLOT, REG_IDENTITY), ID);
    wr(wa(SLOT, REG_SECOND), 16'hA55A);
    rdchk("second", wa(SLOT, REG_SECOND), 16'hA55A);
    $display("test whole registers done");
    for (int c = 0; c < NUM_SH; c++)
    begin
      wr(ca(SLOT, 3'(c), REG_GAIN), g[c]);
      chk("gain out", g[c], gain_code_out[c]);
      rdchk("gain read", ca(SLOT, 3'(c), REG_GAIN), g[c]);
    end
    wr(ca(SLOT, 3'h0, REG_GAIN), 16'hFFF4);
    chk("bad gain", GAIN_X8, gain_code_out[0]);
    wr(ca(SLOT, 3'h4, REG_GAIN), GAIN_X8);
    chk("direct gain", GAIN_UNITY, gain_code_out[4]);
    wr(ca(SLOT, 3'h4, REG_GAIN), GAIN_UNITY);
    rdchk("direct read", ca(SLOT, 3'h4, REG_GAIN), GAIN_UNITY);
    $display("test gain done");
    for (int k = 0; k < 5; k++)
    begin
      wr(ca(SLOT, 3'h1, REG_CUTOFF), {12'hABC, 4'(k)});
      chk("cutoff out", {12'h000, 4'(k)}, {12'h000, cutoff_code_out[1]});
      rdchk("cutoff read", ca(SLOT, 3'h1, REG_CUTOFF), {12'h000, 4'(k)});
    end
    wr(ca(SLOT, 3'h1, REG_CUTOFF), 16'h0005);
    chk("bad cutoff", 16'h0004, {12'h000, cutoff_code_out[1]});
    wr(ca(SLOT, 3'h5, REG_CUTOFF), 16'h0003);
    chk("direct cutoff", 16'h0000, {12'h000, cutoff_code_out[5]});
    $display("test cutoff done");
    wr(ca(OTHER, 3'h0, REG_GAIN), GAIN_HALF);
    chk("other slot", GAIN_X8, gain_code_out[0]);
    i_pcr_host_model.xfer(1'b0, wa(OTHER, REG_IDENTITY), 16'h0000, r);
    chk("other read", 16'h0000, {15'h0000, r.valid});
    $display("test slot match done");
    i_pcr_host_model.set_detect(1'b1);
    chk("detect on", 16'h0001, 16'(open_input_detect));
    i_pcr_host_model.set_detect(1'b0);
    chk("detect off", 16'h0000, 16'(open_input_detect));
    $display("test detect done");
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    #1;
    for (int c = 0; c < NUM_SH; c++)
    begin
      chk("gain cmd", GAIN_HALF, gain_code_out[c]);
      chk("cutoff cmd", 16'h0000, 16'(cutoff_code_out[c]));
    end
    rdchk("second cmd", wa(SLOT, REG_SECOND), SECOND_RESET);
    $display("test reset command done");
    end_sim();
  end

  // Guards against a hung bus.
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule

`default_nettype wire
